// File: hdl/adccrb_top.sv
// Register bank of the ADC: result and configuration registers
module adccrb_top
(
    input  wire logic                              i_ref_clk,          // Core clock
    input  wire logic                              i_rst,              // Async reset, active high
    input  wire logic [adccrb_pkg::PTR_W-1:0]      i_ptr,              // Register pointer
    input  wire logic                              i_wr,               // Write strobe, one cycle
    input  wire logic [adccrb_pkg::CFG_W-1:0]      i_wdata,            // Written word
    input  wire logic                              i_conv_done,        // Conversion finished pulse
    input  wire logic [adccrb_pkg::RESULT_W-1:0]   i_conv_data,        // Finished result
    input  wire logic                              i_cs_n,             // Chip select, active low
    output logic      [adccrb_pkg::RESULT_W-1:0]   o_rdata,            // Read data
    output logic                                   o_conv_run,         // Converter running
    output logic                                   o_conv_start,       // Conversion begin pulse
    output logic      [2:0]                        o_positive_input,   // Positive channel
    output logic      [2:0]                        o_negative_input,   // Negative channel
    output logic      [12:0]                       o_full_scale_range, // Range in mV
    output logic      [2:0]                        o_sample_rate_select, // Data rate code
    output logic                                   o_pullup_en         // Weak pull-up on data line
);
    import adccrb_pkg::*;

    adccrb_cfg_if cfg_bus ();

    logic [RESULT_W-1:0] result_reg;   // Latest conversion
    logic [RESULT_W-1:0] result_next;
    logic [CFG_W-1:0]    config_reg;   // Stored configuration, bit 15 unused
    logic [CFG_W-1:0]    config_next;
    adccrb_state_e       state_reg;    // Conversion state
    adccrb_state_e       state_next;
    logic                start_reg;    // Start pulse register
    logic                start_next;
    logic [2:0]          pair_reg;     // Registered positive channel
    logic [2:0]          neg_reg;      // Registered negative channel
    logic [12:0]         range_reg;    // Registered range in mV
    logic                wr_ok;        // Write carries valid key
    logic                busy;         // A conversion is running
    logic [CFG_W-1:0]    cfg_view;     // Config as read

    adccrb_decode adccrb_decode_inst
    (
        .cfg (cfg_bus.dec)
    );

    assign cfg_bus.input_pair_select = config_reg[MUX_HI:MUX_LO];
    assign cfg_bus.gain_range_select = config_reg[GAIN_HI:GAIN_LO];

    assign wr_ok = i_wr && (i_ptr == PTR_CONFIG) && (i_wdata[PTR_HI:PTR_LO] == WRITE_KEY);

    // Busy whenever a conversion is in progress
    assign busy = (state_reg != ADCCRB_IDLE);

    // Read view of config register
    always_comb
    begin
        cfg_view = (config_reg & CONFIG_WMASK) | CONFIG_FIXED;
        cfg_view[START_BIT] = ~busy;
    end

    // Next-state for config, result and conversion state
    always_comb
    begin
        config_next = config_reg;
        result_next = result_reg;
        state_next  = state_reg;
        start_next  = 1'b0;
        if (wr_ok)
        begin
            // Keep bit 15 storage clear; it is a command, not a setting
            config_next = (i_wdata & CONFIG_WMASK) | CONFIG_FIXED;
            config_next[START_BIT] = 1'b0;
        end
        if (i_conv_done && busy)
        begin
            result_next = i_conv_data;
        end
        unique case (state_reg)
            ADCCRB_IDLE:
            begin
                if (wr_ok && i_wdata[START_BIT] && config_reg[MODE_BIT] && i_wdata[MODE_BIT])
                begin
                    state_next = ADCCRB_CONV;
                    start_next = 1'b1;
                end
                else if (!config_next[MODE_BIT])
                begin
                    state_next = ADCCRB_CONT;
                    start_next = 1'b1;
                end
            end
            ADCCRB_CONV:
            begin
                if (i_conv_done)
                begin
                    state_next = config_next[MODE_BIT] ? ADCCRB_IDLE : ADCCRB_CONT;
                    start_next = !config_next[MODE_BIT];
                end
            end
            ADCCRB_CONT:
            begin
                // Restart after each result; mode change ends the run at the next result
                if (i_conv_done)
                begin
                    state_next = config_next[MODE_BIT] ? ADCCRB_IDLE : ADCCRB_CONT;
                    start_next = !config_next[MODE_BIT];
                end
            end
        endcase
    end

    // State registers
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            // config reset value
            // Stored start bit of the reset word is already clear
            config_reg <= CONFIG_RESET;
            result_reg <= RESULT_RESET;
            state_reg  <= ADCCRB_IDLE;
            start_reg  <= 1'b0;
        end
        else
        begin
            config_reg <= config_next;
            result_reg <= result_next;
            state_reg  <= state_next;
            start_reg  <= start_next;
        end
    end

    // Registered decode outputs
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pair_reg  <= CH_INPUT_0;
            neg_reg   <= CH_INPUT_1;
            range_reg <= RANGE_MV_2;
        end
        else
        begin
            pair_reg  <= cfg_bus.positive_input;
            neg_reg   <= cfg_bus.negative_input;
            range_reg <= cfg_bus.full_scale_range;
        end
    end

    // Read mux, combinational on pointer
    always_comb
    begin
        unique case (i_ptr)
            PTR_RESULT: o_rdata = result_reg;
            PTR_CONFIG: o_rdata = {8'h00, cfg_view};
            default:    o_rdata = '0;
        endcase
    end

    assign o_conv_run           = busy;
    assign o_conv_start         = start_reg;
    assign o_positive_input     = pair_reg;
    assign o_negative_input     = neg_reg;
    assign o_full_scale_range   = range_reg;
    assign o_sample_rate_select = config_reg[RATE_HI:RATE_LO];
    assign o_pullup_en          = config_reg[PULLUP_BIT] && i_cs_n;
endmodule

// File: hdl/adccrb_pkg.sv
// Constants and types for the ADC control register bank
package adccrb_pkg;
    localparam int          RESULT_W        = 24;
    localparam int          CFG_W           = 16;
    localparam int          PTR_W           = 2;
    localparam logic [1:0]  PTR_RESULT      = 2'h0;
    localparam logic [1:0]  PTR_CONFIG      = 2'h1;
    localparam logic [23:0] RESULT_RESET    = 24'h000000;
    localparam logic [15:0] CONFIG_RESET    = 16'h058B;
    localparam int          START_BIT       = 15;
    localparam int          MUX_HI          = 14;
    localparam int          MUX_LO          = 12;
    localparam int          GAIN_HI         = 11;
    localparam int          GAIN_LO         = 9;
    localparam int          MODE_BIT        = 8;
    localparam int          RATE_HI         = 7;
    localparam int          RATE_LO         = 5;
    localparam int          PULLUP_BIT      = 3;
    localparam int          PTR_HI          = 2;
    localparam int          PTR_LO          = 1;
    localparam logic [1:0]  WRITE_KEY       = 2'h1;
    // Writable bits: start, mux, gain, mode, rate, pull-up, pointer
    localparam logic [15:0] CONFIG_WMASK    = 16'hFFEE;
    // Bits 4 and 0 read as their reset values
    localparam logic [15:0] CONFIG_FIXED    = 16'h0001;
    localparam logic [2:0]  CH_INPUT_0      = 3'h0;
    localparam logic [2:0]  CH_INPUT_1      = 3'h1;
    localparam logic [2:0]  CH_INPUT_2      = 3'h2;
    localparam logic [2:0]  CH_INPUT_3      = 3'h3;
    localparam logic [2:0]  CH_GND          = 3'h4;
    // Full-scale range in millivolts, per gain code
    localparam logic [12:0] RANGE_MV_0      = 13'h1800;
    localparam logic [12:0] RANGE_MV_1      = 13'h1000;
    localparam logic [12:0] RANGE_MV_2      = 13'h0800;
    localparam logic [12:0] RANGE_MV_3      = 13'h0400;
    localparam logic [12:0] RANGE_MV_4      = 13'h0200;
    localparam logic [12:0] RANGE_MV_5      = 13'h0100;
    localparam logic [12:0] RANGE_MV_6      = 13'h0080;
    localparam logic [12:0] RANGE_MV_7      = 13'h0040;

    typedef enum logic [1:0] {ADCCRB_IDLE, ADCCRB_CONV, ADCCRB_CONT} adccrb_state_e;
endpackage

// File: hdl/adccrb_cfg_if.sv
// Configuration fields passed from the register bank to its decoder
interface adccrb_cfg_if;
    logic [2:0]  input_pair_select;  // Mux code
    logic [2:0]  gain_range_select;  // Gain code
    logic [2:0]  positive_input;     // Decoded positive channel
    logic [2:0]  negative_input;     // Decoded negative channel
    logic [12:0] full_scale_range;   // Range in millivolts

    modport bank (output input_pair_select, output gain_range_select,
                  input positive_input, input negative_input, input full_scale_range);
    modport dec  (input input_pair_select, input gain_range_select,
                  output positive_input, output negative_input, output full_scale_range);
endinterface

// File: hdl/adccrb_decode.sv
// Decoder of input pair and gain range codes
module adccrb_decode
(
    adccrb_cfg_if.dec cfg
);
    import adccrb_pkg::*;

    // Input pair decode
    always_comb
    begin
        cfg.positive_input = CH_INPUT_0;
        cfg.negative_input = CH_INPUT_1;
        unique case (cfg.input_pair_select)
            3'h0:
            begin
                cfg.positive_input = CH_INPUT_0;
                cfg.negative_input = CH_INPUT_1;
            end
            3'h1:
            begin
                cfg.positive_input = CH_INPUT_0;
                cfg.negative_input = CH_INPUT_3;
            end
            3'h2:
            begin
                cfg.positive_input = CH_INPUT_1;
                cfg.negative_input = CH_INPUT_3;
            end
            3'h3:
            begin
                cfg.positive_input = CH_INPUT_2;
                cfg.negative_input = CH_INPUT_3;
            end
            3'h4:
            begin
                cfg.positive_input = CH_INPUT_0;
                cfg.negative_input = CH_GND;
            end
            3'h5:
            begin
                cfg.positive_input = CH_INPUT_1;
                cfg.negative_input = CH_GND;
            end
            3'h6:
            begin
                cfg.positive_input = CH_INPUT_2;
                cfg.negative_input = CH_GND;
            end
            3'h7:
            begin
                cfg.positive_input = CH_INPUT_3;
                cfg.negative_input = CH_GND;
            end
        endcase
    end

    // Gain range decode
    always_comb
    begin
        cfg.full_scale_range = RANGE_MV_2;
        unique case (cfg.gain_range_select)
            3'h0: cfg.full_scale_range = RANGE_MV_0;
            3'h1: cfg.full_scale_range = RANGE_MV_1;
            3'h2: cfg.full_scale_range = RANGE_MV_2;
            3'h3: cfg.full_scale_range = RANGE_MV_3;
            3'h4: cfg.full_scale_range = RANGE_MV_4;
            3'h5: cfg.full_scale_range = RANGE_MV_5;
            3'h6: cfg.full_scale_range = RANGE_MV_6;
            3'h7: cfg.full_scale_range = RANGE_MV_7;
        endcase
    end
endmodule

// File: tb/adccrb_top_asserts.sv
// Checker of the register bank, bound to the top module ports
module adccrb_top_asserts
(
    input wire logic                            i_ref_clk,
    input wire logic                            i_rst,
    input wire logic [adccrb_pkg::PTR_W-1:0]    i_ptr,
    input wire logic                            i_wr,
    input wire logic [adccrb_pkg::CFG_W-1:0]    i_wdata,
    input wire logic                            i_conv_done,
    input wire logic [adccrb_pkg::RESULT_W-1:0] i_conv_data,
    input wire logic                            i_cs_n,
    input wire logic [adccrb_pkg::RESULT_W-1:0] o_rdata,
    input wire logic                            o_conv_run,
    input wire logic                            o_conv_start,
    input wire logic [12:0]                     o_full_scale_range,
    input wire logic [2:0]                      o_sample_rate_select,
    input wire logic                            o_pullup_en
);
    import adccrb_pkg::*;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    // Range in mV per gain code, halving from code 1 on
    function automatic logic [12:0] range_of(input logic [2:0] c);
        return (c == 3'h0) ? 13'h1800 : (13'h1000 >> (c - 3'h1));
    endfunction
    property p_fixed; i_ptr == PTR_CONFIG |-> o_rdata[23:16] == 8'h00 && !o_rdata[4] && o_rdata[0]; endproperty
    a_fixed: assert property (p_fixed) else $error("config fixed bits wrong");
    property p_busy; i_ptr == PTR_CONFIG |-> o_rdata[15] == !o_conv_run; endproperty
    a_busy: assert property (p_busy) else $error("busy flag wrong");
    // Start write is taken when idle in single-shot mode with a valid key
    property p_start; i_wr && i_ptr == PTR_CONFIG && i_wdata[2:1] == WRITE_KEY && i_wdata[15] && i_wdata[8]
        && o_rdata[8] && !o_conv_run |=> o_conv_start && o_conv_run; endproperty
    a_start: assert property (p_start) else $error("start write not taken");
    property p_key; i_wr && i_ptr == PTR_CONFIG && i_wdata[2:1] != WRITE_KEY && o_rdata[8] && !o_conv_run
        |=> !o_conv_start; endproperty
    a_key: assert property (p_key) else $error("keyless write acted");
    property p_result; o_conv_run && i_conv_done |=> i_ptr != PTR_RESULT || o_rdata == $past(i_conv_data); endproperty
    a_result: assert property (p_result) else $error("result not updated");
    property p_end; o_conv_run && i_conv_done && i_ptr == PTR_CONFIG && o_rdata[8] |=> !o_conv_run; endproperty
    a_end: assert property (p_end) else $error("single shot did not stop");
    property p_pull; i_ptr == PTR_CONFIG |-> o_pullup_en == (i_cs_n && o_rdata[PULLUP_BIT]); endproperty
    a_pull: assert property (p_pull) else $error("pull-up enable wrong");
    property p_rate; i_ptr == PTR_CONFIG |-> o_sample_rate_select == o_rdata[7:5]; endproperty
    a_rate: assert property (p_rate) else $error("rate code wrong");
    // Decoded range lags the register by one cycle
    property p_fsr; i_ptr == PTR_CONFIG ##1 (i_ptr == PTR_CONFIG && $stable(o_rdata[11:9]))
        |-> o_full_scale_range == range_of(o_rdata[11:9]); endproperty
    a_fsr: assert property (p_fsr) else $error("range decode wrong");
endmodule
bind adccrb_top adccrb_top_asserts adccrb_top_asserts_inst (.i_ref_clk, .i_rst, .i_ptr, .i_wr, .i_wdata,
    .i_conv_done, .i_conv_data, .i_cs_n, .o_rdata, .o_conv_run, .o_conv_start, .o_full_scale_range,
    .o_sample_rate_select, .o_pullup_en);

// File: tb/adccrb_conv_model.sv
// Converter model: answers each start pulse after a set delay
module adccrb_conv_model
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst,
    input  wire logic        i_start,
    input  wire logic [7:0]  i_lat,
    input  wire logic [23:0] i_value,
    output logic             o_done = 1'b0,
    output logic [23:0]      o_data = 24'h5A5A5A
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] cnt_reg = 8'h00; // Cycles left in the running conversion
    // Data inverts every cycle outside the done cycle, so a stale value matches only in alternate cycles
    always @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            cnt_reg <= 8'h00;
        else
            cnt_reg <= i_start ? i_lat : (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
        o_done <= !i_rst && cnt_reg == 8'h01;
        o_data <= (cnt_reg == 8'h01) ? i_value : ~o_data;
    end
endmodule

// File: tb/adccrb_top_tb.sv
// Self-checking bench of the ADC register bank
module adccrb_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import adccrb_pkg::*;
    logic        i_ref_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [1:0]  i_ptr = 2'h0;
    logic        i_wr = 1'b0;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_cs_n = 1'b1;
    logic        i_conv_done, o_conv_run, o_conv_start, o_pullup_en;
    logic [23:0] i_conv_data, o_rdata;
    logic [2:0]  o_positive_input, o_negative_input, o_sample_rate_select;
    logic [12:0] o_full_scale_range;
    logic [7:0]  lat = 8'h0A;
    logic [23:0] value = 24'h800001;
    logic [5:0]  pairs [8] = '{6'o01, 6'o03, 6'o13, 6'o23, 6'o04, 6'o14, 6'o24, 6'o34};
    logic [12:0] range_mv [8] = '{13'h1800, 13'h1000, 13'h0800, 13'h0400, 13'h0200, 13'h0100, 13'h0080, 13'h0040};
    int          err_count = 0;
    int          samples_checked = 0;
    always #2 i_ref_clk = ~i_ref_clk;
    adccrb_top adccrb_top_inst (.i_ref_clk, .i_rst, .i_ptr, .i_wr, .i_wdata, .i_conv_done, .i_conv_data, .i_cs_n,
        .o_rdata, .o_conv_run, .o_conv_start, .o_positive_input, .o_negative_input, .o_full_scale_range,
        .o_sample_rate_select, .o_pullup_en);
    adccrb_conv_model adccrb_conv_model_inst (.i_ref_clk, .i_rst, .i_start(o_conv_start), .i_lat(lat),
        .i_value(value), .o_done(i_conv_done), .o_data(i_conv_data));
    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One-cycle write strobe taken at the rising edge between two falling edges
    task automatic wr(input logic [1:0] p, input logic [15:0] d);
        @(negedge i_ref_clk);
        i_ptr = p;
        i_wr = 1'b1;
        i_wdata = d;
        @(negedge i_ref_clk);
        i_wr = 1'b0;
    endtask
    task automatic rd(input logic [1:0] p, input logic [23:0] exp);
        @(negedge i_ref_clk);
        i_ptr = p;
        #1 check(o_rdata, exp);
    endtask
    // Bounded wait for the converter to go idle
    task automatic wait_idle();
        int n = 0;
        while (o_conv_run !== 1'b0 && n < 100)
        begin
            @(negedge i_ref_clk);
            n++;
        end
        if (o_conv_run !== 1'b0)
        begin
            err_count++;
            give_verdict();
        end
    endtask
    task automatic t_reset();
        rd(PTR_RESULT, 24'h000000);
        // Stored word is the reset value; bit 15 reads as idle
        rd(PTR_CONFIG, 24'h00858B);
        check(24'({o_positive_input, o_negative_input}), 24'h000001);
        check(24'(o_full_scale_range), 24'h000800);
        check(24'(o_sample_rate_select), 24'h000004);
        check(24'(o_pullup_en), 24'h000001);
        @(negedge i_ref_clk);
        i_cs_n = 1'b0;
        #1 check(24'(o_pullup_en), 24'h000000);
    endtask
    // Single shot, busy refusal, read-only result, zero start ignored
    task automatic t_single();
        wr(PTR_CONFIG, 16'h8583);
        check(24'({o_conv_start, o_conv_run}), 24'h000003);
        rd(PTR_CONFIG, 24'h000583);
        wr(PTR_CONFIG, 16'h8583);
        check(24'(o_conv_start), 24'h000000);
        rd(PTR_RESULT, 24'h000000);
        wait_idle();
        rd(PTR_RESULT, 24'h800001);
        wr(PTR_RESULT, 16'h0003);
        rd(PTR_RESULT, 24'h800001);
        wr(PTR_CONFIG, 16'h0583);
        check(24'(o_conv_start), 24'h000000);
        rd(PTR_CONFIG, 24'h008583);
    endtask
    task automatic t_key();
        wr(PTR_CONFIG, 16'hFFE5);
        check(24'(o_conv_start), 24'h000000);
        rd(PTR_CONFIG, 24'h008583);
    endtask
    // Every mux, gain and rate code; mux and gain decoded one cycle after the register, rate read straight from it
    task automatic t_fields();
        for (int c = 0; c < 8; c++)
        begin
            wr(PTR_CONFIG, {1'b0, 3'(c), 3'(7 - c), 1'b1, 3'(c), 5'h0B});
            @(negedge i_ref_clk);
            check(24'({o_positive_input, o_negative_input}), 24'(pairs[c]));
            check(24'(o_full_scale_range), 24'(range_mv[7 - c]));
            check(24'(o_sample_rate_select), 24'(c));
        end
        i_cs_n = 1'b1;
        #1 check(24'(o_pullup_en), 24'h000001);
    endtask
    // Continuous mode restarts itself until single-shot is chosen again
    task automatic t_cont();
        int n = 0;
        lat = 8'h03;
        wr(PTR_CONFIG, 16'h0483);
        repeat (30)
        begin
            @(negedge i_ref_clk);
            n += int'(o_conv_start === 1'b1);
        end
        check(24'(n >= 3), 24'h000001);
        wr(PTR_CONFIG, 16'h0583);
        wait_idle();
        rd(PTR_CONFIG, 24'h008583);
    endtask
    // Reset in mid-conversion clears the result and restores the defaults
    task automatic t_rerun();
        wr(PTR_CONFIG, 16'h8583);
        check(24'(o_conv_run), 24'h000001);
        i_rst = 1'b1;
        repeat (3) @(negedge i_ref_clk);
        i_rst = 1'b0;
        check(24'({o_conv_start, o_conv_run}), 24'h000000);
        rd(PTR_RESULT, 24'h000000);
        rd(PTR_CONFIG, 24'h00858B);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_rst = 1'b0;
        t_reset();
        t_single();
        t_key();
        t_fields();
        t_cont();
        t_rerun();
        give_verdict();
    end
endmodule
